// ### src/qrw_top.sv
// Quad read, burst wrap, software reset and deep power-down command handling
// Behaviour
// - Quad read: address, mode byte, four dummy clocks
// - Low mode nibble is ignored
// - Field 10 skips opcode on next read
// - Other field values need opcode again
// - Reset ignored while continuous read active
// - Wrapped output loops within aligned section
// - Wrap command: opcode, 24 dummy, wrap byte
// - Only wrap bits six to four stored
// - Disable zero wraps 8/16/32/64 bytes
// - Wrap setting persists until next wrap command or accepted reset
// - Quad commands outside continuous read need quad enable set
// - Wrapping disabled at power-on
// - Accepted reset restores volatile defaults
// - Reset ignored while powered down
// - Reset needs enable immediately before
// - Any other command outside power-down disarms reset
// - Power-down needs select rise after bit eight
// - Powered down: only release recognized
// - Power-up never starts powered down
`timescale 1ns/10ps
module qrw_top (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        spi_clk,
	input  wire logic        spi_cs_n,
	input  wire logic [3:0]  quad_io_in,
	output logic      [3:0]  quad_io_out,
	output logic      [3:0]  quad_io_oe,
	input  wire logic        quad_enable,
	output logic             rd_req_valid,
	input  wire logic        rd_req_ready,
	output logic      [23:0] rd_req_addr,
	input  wire logic [7:0]  rd_data,
	output logic      [2:0]  wrap_bits,
	output logic             cont_mode,
	output logic             power_down,
	output logic             soft_reset
);
	logic [2:0]  clk_s_ff;
	logic [1:0]  cs_s_ff;
	logic [7:0]  io_s_ff;
	logic        rise;
	logic        fall;
	logic        cs_n;
	logic [3:0]  io;
	logic        cs_fall;
	logic        cs_rise;
	qrw_pkg::qrw_state_t st_ff;
	logic [5:0]  cnt_ff;
	logic [7:0]  sh_ff;
	logic [23:0] addr_ff;
	logic        nib_ff;
	logic        cont_ff;
	logic        rst_arm_ff;
	logic        pd_ff;
	logic        pd_pend_ff;
	logic        rel_pend_ff;
	logic [8:0]  dly_ff;
	logic [2:0]  wrap_ff;
	logic        opc_ok_ff;
	logic [7:0]  opc_ff;
	logic [3:0]  out_ff;
	logic        oe_ff;
	logic        srst_ff;
	logic        req_ff;
	logic        fifo_ready;
	logic        ev_opc;
	logic [7:0]  opc_now;

	// Pin synchronisers, second stage onward feed logic
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			clk_s_ff <= '0;
			cs_s_ff  <= 2'h3;
			io_s_ff  <= '0;
		end
		else
		begin
			clk_s_ff <= {clk_s_ff[1:0], spi_clk};
			cs_s_ff  <= {cs_s_ff[0], spi_cs_n};
			io_s_ff  <= {io_s_ff[3:0], quad_io_in};
		end
	end
	assign rise    = clk_s_ff[1] && !clk_s_ff[2] && !cs_n;
	assign fall    = !clk_s_ff[1] && clk_s_ff[2] && !cs_n;
	assign cs_n    = cs_s_ff[1];
	assign io      = io_s_ff[7:4];
	assign opc_now = {sh_ff[6:0], io[0]};
	assign ev_opc  = rise && st_ff == qrw_pkg::ST_OPC && cnt_ff == qrw_pkg::OPC_BITS - 6'h01;

	logic cs_d_ff;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cs_d_ff <= 1'b1;
		else
			cs_d_ff <= cs_n;
	end
	assign cs_fall = cs_d_ff && !cs_n;
	assign cs_rise = !cs_d_ff && cs_n;

	// Command framing state machine
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || srst_ff)
		begin
			st_ff   <= qrw_pkg::ST_OPC;
			cnt_ff  <= '0;
			sh_ff   <= '0;
			addr_ff <= '0;
			opc_ff  <= '0;
			nib_ff  <= 1'b0;
		end
		else if (cs_fall)
		begin
			cnt_ff <= '0;
			nib_ff <= 1'b0;
			st_ff  <= (cont_ff && !pd_ff) ? qrw_pkg::ST_ADDR : qrw_pkg::ST_OPC;
			opc_ff <= (cont_ff && !pd_ff) ? qrw_pkg::CMD_QUAD_READ : 8'h00;
		end
		else if (rise)
		begin
			cnt_ff <= cnt_ff + 6'h01;
			case (st_ff)
				qrw_pkg::ST_OPC:
				begin
					sh_ff <= opc_now;
					if (ev_opc)
					begin
						cnt_ff <= '0;
						opc_ff <= opc_now;
						if (pd_ff)
							st_ff <= qrw_pkg::ST_IGN;
						else if (opc_now == qrw_pkg::CMD_QUAD_READ && quad_enable)
							st_ff <= qrw_pkg::ST_ADDR;
						else if (opc_now == qrw_pkg::CMD_SET_WRAP && quad_enable)
							st_ff <= qrw_pkg::ST_WRAP;
						else
							st_ff <= qrw_pkg::ST_IGN;
					end
				end
				qrw_pkg::ST_ADDR:
				begin
					addr_ff <= {addr_ff[19:0], io};
					if (cnt_ff == qrw_pkg::ADDR_NIB - 6'h01)
					begin
						cnt_ff <= '0;
						st_ff  <= qrw_pkg::ST_MODE;
					end
				end
				qrw_pkg::ST_MODE:
				begin
					sh_ff <= {sh_ff[3:0], io};
					if (cnt_ff == qrw_pkg::MODE_NIB - 6'h01)
					begin
						cnt_ff <= '0;
						st_ff  <= qrw_pkg::ST_DUMMY;
					end
				end
				qrw_pkg::ST_DUMMY:
					if (cnt_ff == qrw_pkg::DUMMY_NIB - 6'h01)
					begin
						cnt_ff <= '0;
						st_ff  <= qrw_pkg::ST_DATA;
					end
				qrw_pkg::ST_DATA:
				begin
					nib_ff <= !nib_ff;
					if (nib_ff)
						addr_ff <= next_addr(addr_ff, wrap_ff);
				end
				qrw_pkg::ST_WRAP:
				begin
					sh_ff <= {sh_ff[3:0], io};
					if (cnt_ff == qrw_pkg::WRAP_DUMMY_NIB + qrw_pkg::WRAP_BYTE_NIB - 6'h01)
						st_ff <= qrw_pkg::ST_IGN;
				end
				qrw_pkg::ST_IGN:
					if (&cnt_ff)
						cnt_ff <= cnt_ff;
				default:
					st_ff <= qrw_pkg::ST_IGN;
			endcase
		end
	end

	// Wrap address step: with wrap enabled only bits inside the section move
	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [2:0] w);
		logic [23:0] m;
		logic [23:0] inc;
		m = 24'h000007;
		case (w[2:1])
			2'h0: m = 24'h000007;
			2'h1: m = 24'h00000F;
			2'h2: m = 24'h00001F;
			default: m = 24'h00003F;
		endcase
		inc = a + 24'h000001;
		if (w[0])
			next_addr = inc;
		else
			next_addr = (a & ~m) | (inc & m);
	endfunction

	// Continuous read mode latch
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cont_ff <= 1'b0;
		else if (rise && st_ff == qrw_pkg::ST_MODE && cnt_ff == qrw_pkg::MODE_NIB - 6'h01)
			cont_ff <= sh_ff[1:0] == qrw_pkg::CONT_KEEP;
		else if (ev_opc)
			cont_ff <= 1'b0;
	end

	// Wrap setting register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || srst_ff)
			wrap_ff <= qrw_pkg::WRAP_RESET;
		else if (rise && st_ff == qrw_pkg::ST_WRAP
			&& cnt_ff == qrw_pkg::WRAP_DUMMY_NIB + qrw_pkg::WRAP_BYTE_NIB - 6'h01)
			wrap_ff <= sh_ff[2:0];
	end

	// Reset arming and power-down control on chip select rise
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rst_arm_ff  <= 1'b0;
			srst_ff     <= 1'b0;
			pd_ff       <= 1'b0;
			pd_pend_ff  <= 1'b0;
			rel_pend_ff <= 1'b0;
			dly_ff      <= '0;
		end
		else
		begin
			srst_ff <= 1'b0;
			if (cs_rise && st_ff == qrw_pkg::ST_IGN && cnt_ff == '0)
			begin
				if (pd_ff)
				begin
					if (opc_ff == qrw_pkg::CMD_RELEASE_PD)
					begin
						rel_pend_ff <= 1'b1;
						dly_ff      <= qrw_pkg::PD_EXIT_CNT;
					end
				end
				else if (!cont_ff)
				begin
					rst_arm_ff <= opc_ff == qrw_pkg::CMD_RESET_ENABLE;
					if (opc_ff == qrw_pkg::CMD_RESET && rst_arm_ff)
						srst_ff <= 1'b1;
					if (opc_ff == qrw_pkg::CMD_POWER_DOWN)
					begin
						pd_pend_ff <= 1'b1;
						dly_ff     <= qrw_pkg::PD_ENTRY_CNT;
					end
				end
			end
			else if (cs_rise && !pd_ff)
				rst_arm_ff <= 1'b0;
			if (pd_pend_ff || rel_pend_ff)
			begin
				if (dly_ff != '0)
					dly_ff <= dly_ff - 9'h001;
				else
				begin
					pd_ff       <= pd_pend_ff;
					pd_pend_ff  <= 1'b0;
					rel_pend_ff <= 1'b0;
				end
			end
		end
	end

	// Read request path and output shifter
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			req_ff <= 1'b0;
		else
			req_ff <= !cs_n && st_ff == qrw_pkg::ST_DATA && !nib_ff && rise;
	end

	qrw_fifo #(.W(qrw_pkg::FIFO_W), .D(qrw_pkg::FIFO_D)) u_req_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (req_ff),
		.in_ready  (fifo_ready),
		.in_data   (addr_ff),
		.out_valid (rd_req_valid),
		.out_ready (rd_req_ready),
		.out_data  (rd_req_addr)
	);

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			out_ff <= '0;
			oe_ff  <= 1'b0;
		end
		else if (cs_n)
			oe_ff <= 1'b0;
		else if (fall && st_ff == qrw_pkg::ST_DATA)
		begin
			oe_ff  <= 1'b1;
			out_ff <= nib_ff ? rd_data[3:0] : rd_data[7:4];
		end
	end

	assign quad_io_out = out_ff;
	assign quad_io_oe  = {4{oe_ff}};
	assign wrap_bits   = wrap_ff;
	assign cont_mode   = cont_ff;
	assign power_down  = pd_ff;
	assign soft_reset  = srst_ff;

	a_wrap_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		srst_ff |=> wrap_ff == qrw_pkg::WRAP_RESET)
		else $error("wrap bits not restored by reset");
	a_pd_blocks_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ev_opc && pd_ff) |=> st_ff == qrw_pkg::ST_IGN)
		else $error("command taken in power-down");
	a_no_qe_quad: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ev_opc && !quad_enable && !pd_ff) |=> st_ff == qrw_pkg::ST_IGN)
		else $error("quad command without quad enable");
	a_cont_no_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		cont_ff |=> !srst_ff)
		else $error("reset in continuous mode");
	a_pd_no_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		pd_ff |=> !srst_ff)
		else $error("reset while powered down");
	a_cont_skip_opc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cs_fall && cont_ff && !pd_ff) |=> st_ff == qrw_pkg::ST_ADDR)
		else $error("opcode not skipped");
	a_cont_need_opc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cs_fall && !cont_ff) |=> st_ff == qrw_pkg::ST_OPC)
		else $error("opcode phase missing");
	a_wrap_hold_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rise && st_ff == qrw_pkg::ST_DATA && nib_ff && !wrap_ff[0] && !cs_fall && !srst_ff)
		|=> addr_ff[23:6] == $past(addr_ff[23:6]))
		else $error("upper address moved in wrap");
	a_srst_needs_arm: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(srst_ff) |-> $past(rst_arm_ff))
		else $error("reset without enable");
	a_req_no_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
		req_ff |-> fifo_ready)
		else $error("read request dropped");
	c_cont_read: cover property (@(posedge core_clk) disable iff (!rst_n) cs_fall && cont_ff);
	c_wrap_set: cover property (@(posedge core_clk) disable iff (!rst_n) $changed(wrap_ff));
	c_soft_reset: cover property (@(posedge core_clk) disable iff (!rst_n) srst_ff);
	c_power_down: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(pd_ff));
endmodule

// ### src/qrw_pkg.sv
// Package with command codes, field positions and timing constants of the quad command block
package qrw_pkg;
	localparam logic [7:0] CMD_QUAD_READ     = 8'hEB;
	localparam logic [7:0] CMD_SET_WRAP      = 8'h77;
	localparam logic [7:0] CMD_RESET_ENABLE  = 8'h66;
	localparam logic [7:0] CMD_RESET         = 8'h99;
	localparam logic [7:0] CMD_POWER_DOWN    = 8'hB9;
	localparam logic [7:0] CMD_RELEASE_PD    = 8'hAB;
	localparam logic [1:0] CONT_KEEP         = 2'h2;
	localparam int         CONT_LO           = 4;
	localparam int         WRAP_LO           = 4;
	localparam logic [2:0] WRAP_RESET        = 3'h1;
	localparam logic [5:0] OPC_BITS          = 6'h08;
	localparam logic [5:0] ADDR_NIB          = 6'h06;
	localparam logic [5:0] MODE_NIB          = 6'h02;
	localparam logic [5:0] DUMMY_NIB         = 6'h04;
	localparam logic [5:0] WRAP_DUMMY_NIB    = 6'h06;
	localparam logic [5:0] WRAP_BYTE_NIB     = 6'h02;
	localparam int         CLK_NS            = 25;
	localparam int         PD_ENTRY_NS       = 3000;
	localparam int         PD_EXIT_NS        = 8000;
	localparam int         PD_ENTRY_CYC      = (PD_ENTRY_NS + CLK_NS - 1) / CLK_NS;
	localparam int         PD_EXIT_CYC       = (PD_EXIT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [8:0] PD_ENTRY_CNT      = 9'(PD_ENTRY_CYC);
	localparam logic [8:0] PD_EXIT_CNT       = 9'(PD_EXIT_CYC);
	localparam int         FIFO_W            = 24;
	localparam int         FIFO_D            = 16;
	typedef enum logic [6:0]
	{
		ST_OPC   = 7'h01,
		ST_ADDR  = 7'h02,
		ST_MODE  = 7'h04,
		ST_DUMMY = 7'h08,
		ST_DATA  = 7'h10,
		ST_WRAP  = 7'h20,
		ST_IGN   = 7'h40
	} qrw_state_t;
endpackage

// ### src/qrw_fifo.sv
// FIFO of flip-flops with valid and ready on both sides
`timescale 1ns/10ps
module qrw_fifo #(
	parameter int W = 24,
	parameter int D = 16
)(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_ff [D];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;
	assign in_ready  = (cnt_ff != (AW+1)'(D));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_ff[wr_ff] <= in_data;
	end
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ff <= wr_ff + AW'(1);
			if (pop)
				rd_ff <= rd_ff + AW'(1);
			if (push && !pop)
				cnt_ff <= cnt_ff + (AW+1)'(1);
			else if (pop && !push)
				cnt_ff <= cnt_ff - (AW+1)'(1);
		end
	end
endmodule

// ### dv/qrw_host.sv
// Host serial controller model driving select, serial clock and the four IO lines
`timescale 1ns/10ps
module qrw_host (
	input  wire logic       core_clk,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe,
	output logic            spi_clk,
	output logic            spi_cs_n,
	output logic      [3:0] io_in
);
	logic [3:0] h_out;
	logic       h_oe;
	logic [3:0] last;
	initial
	begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		h_out = 4'h0;
		h_oe = 1'b0;
		last = 4'h0;
	end
	// Released lines show a changing pattern, never the last value
	assign io_in = dev_oe[0] ? dev_out : (h_oe ? h_out : ~last);
	always @(posedge core_clk)
		last <= io_in;
	task clk1(input logic [3:0] n, input logic drv);
		@(negedge core_clk);
		h_out = n;
		h_oe = drv;
		repeat (4) @(negedge core_clk);
		spi_clk = 1'b1;
		repeat (4) @(negedge core_clk);
		spi_clk = 1'b0;
	endtask
	task byte1(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			clk1({3'h0, b[i]}, 1'b1);
	endtask
	task start();
		@(negedge core_clk);
		spi_cs_n = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	// Select rises right after the last latched bit
	task stop();
		@(negedge core_clk);
		h_oe = 1'b0;
		spi_cs_n = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask
	task cmd(input logic [7:0] b);
		start();
		byte1(b);
		stop();
	endtask
	task quad_read(input logic op, input logic [23:0] a, input logic [7:0] m, input int nb);
		start();
		if (op)
			byte1(qrw_pkg::CMD_QUAD_READ);
		for (int i = 5; i >= 0; i--)
			clk1(a[4*i+:4], 1'b1);
		clk1(m[7:4], 1'b1);
		clk1(m[3:0], 1'b1);
		// Lines released through dummy and data clocks
		repeat (4 + 2 * nb) clk1(4'h0, 1'b0);
		stop();
	endtask
	task set_wrap(input logic [7:0] w);
		start();
		byte1(qrw_pkg::CMD_SET_WRAP);
		repeat (6) clk1(4'h0, 1'b1);
		clk1(w[7:4], 1'b1);
		clk1(w[3:0], 1'b1);
		stop();
	endtask
endmodule

// ### dv/qrw_top_tb.sv
// Self-checking bench of the quad command block
`timescale 1ns/10ps
module qrw_top_tb;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        spi_clk;
	logic        spi_cs_n;
	logic [3:0]  quad_io_in;
	logic [3:0]  quad_io_out;
	logic [3:0]  quad_io_oe;
	logic        quad_enable = 1'b1;
	logic        rd_req_valid;
	logic        rd_req_ready = 1'b0;
	logic [23:0] rd_req_addr;
	logic [7:0]  rd_data = 8'hC3;
	logic [2:0]  wrap_bits;
	logic        cont_mode;
	logic        power_down;
	logic        soft_reset;
	int          err_total = 0;
	int          num_checks = 0;
	int          rst_cnt = 0;
	int          nib_cnt = 0;
	logic [23:0] aq[$];
	always #12.5 core_clk = ~core_clk;
	qrw_top u_qrw_top (.core_clk(core_clk), .rst_n(rst_n), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .quad_io_in(quad_io_in), .quad_io_out(quad_io_out),
		.quad_io_oe(quad_io_oe), .quad_enable(quad_enable), .rd_req_valid(rd_req_valid),
		.rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr), .rd_data(rd_data),
		.wrap_bits(wrap_bits), .cont_mode(cont_mode), .power_down(power_down),
		.soft_reset(soft_reset));
	qrw_host u_qrw_host (.core_clk(core_clk), .dev_out(quad_io_out), .dev_oe(quad_io_oe),
		.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .io_in(quad_io_in));
	always @(posedge core_clk)
	begin
		if (soft_reset === 1'b1)
			rst_cnt++;
		if (rd_req_valid === 1'b1 && rd_req_ready)
			aq.push_back(rd_req_addr);
	end
	// Data nibbles seen by the host at each serial clock rise, high nibble first
	always @(posedge spi_clk)
	begin
		if (quad_io_oe[0] === 1'b1)
		begin
			chk("quad_io_out", nib_cnt[0] ? 24'h3 : 24'hC, {20'h0, quad_io_out});
			nib_cnt++;
		end
	end
	always @(negedge spi_cs_n)
		nib_cnt = 0;
	task chk(input string s, input logic [23:0] e, input logic [23:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task chk_addrs(input logic [23:0] base, input int off, input int n);
		chk("addr count", 24'h1, {23'h0, aq.size() >= n});
		for (int k = 0; k < n && k < aq.size(); k++)
			chk("rd_req_addr", base | 24'((off + k) % 16), aq[k]);
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		print_verdict();
	end
	initial
	begin
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk("wrap_bits", 24'h1, {21'h0, wrap_bits});
		chk("cont_mode", 24'h0, {23'h0, cont_mode});
		chk("power_down", 24'h0, {23'h0, power_down});
		quad_enable = 1'b0;
		u_qrw_host.set_wrap(8'h30);
		chk("wrap_bits", 24'h1, {21'h0, wrap_bits});
		quad_enable = 1'b1;
		for (int l = 0; l < 4; l++)
		begin
			u_qrw_host.set_wrap({1'b1, 2'(l), 1'b0, 4'hA});
			chk("wrap_bits", {21'h0, 2'(l), 1'b0}, {21'h0, wrap_bits});
		end
		u_qrw_host.set_wrap(8'hA5);
		$display("test wrap setting done");
		u_qrw_host.quad_read(1'b1, 24'h00123C, 8'h2F, 6);
		chk("cont_mode", 24'h1, {23'h0, cont_mode});
		@(negedge core_clk);
		rd_req_ready = 1'b1;
		repeat (10) @(negedge core_clk);
		chk_addrs(24'h001230, 12, 6);
		aq.delete();
		u_qrw_host.quad_read(1'b0, 24'h00010E, 8'h2F, 3);
		repeat (10) @(negedge core_clk);
		chk_addrs(24'h000100, 14, 3);
		u_qrw_host.cmd(qrw_pkg::CMD_RESET_ENABLE);
		u_qrw_host.cmd(qrw_pkg::CMD_RESET);
		chk("reset count", 24'h0, 24'(rst_cnt));
		chk("wrap_bits", 24'h2, {21'h0, wrap_bits});
		u_qrw_host.quad_read(1'b1, 24'h000000, 8'h20, 0);
		chk("cont_mode", 24'h1, {23'h0, cont_mode});
		u_qrw_host.cmd(8'hFF);
		chk("cont_mode", 24'h0, {23'h0, cont_mode});
		$display("test quad read done");
		u_qrw_host.cmd(qrw_pkg::CMD_RESET_ENABLE);
		u_qrw_host.cmd(qrw_pkg::CMD_RELEASE_PD);
		u_qrw_host.cmd(qrw_pkg::CMD_RESET);
		chk("reset count", 24'h0, 24'(rst_cnt));
		u_qrw_host.cmd(qrw_pkg::CMD_RESET_ENABLE);
		u_qrw_host.cmd(qrw_pkg::CMD_RESET);
		chk("reset count", 24'h1, 24'(rst_cnt));
		chk("wrap_bits", 24'h1, {21'h0, wrap_bits});
		$display("test soft reset done");
		u_qrw_host.start();
		u_qrw_host.byte1(qrw_pkg::CMD_POWER_DOWN);
		u_qrw_host.clk1(4'h1, 1'b1);
		u_qrw_host.stop();
		repeat (140) @(negedge core_clk);
		chk("power_down", 24'h0, {23'h0, power_down});
		u_qrw_host.cmd(qrw_pkg::CMD_POWER_DOWN);
		repeat (140) @(negedge core_clk);
		chk("power_down", 24'h1, {23'h0, power_down});
		u_qrw_host.cmd(qrw_pkg::CMD_RESET_ENABLE);
		u_qrw_host.cmd(qrw_pkg::CMD_RESET);
		u_qrw_host.set_wrap(8'h00);
		chk("reset count", 24'h1, 24'(rst_cnt));
		chk("wrap_bits", 24'h1, {21'h0, wrap_bits});
		u_qrw_host.cmd(qrw_pkg::CMD_RELEASE_PD);
		repeat (340) @(negedge core_clk);
		chk("power_down", 24'h0, {23'h0, power_down});
		u_qrw_host.cmd(qrw_pkg::CMD_RESET_ENABLE);
		u_qrw_host.cmd(qrw_pkg::CMD_RESET);
		chk("reset count", 24'h2, 24'(rst_cnt));
		$display("test power down done");
		print_verdict();
	end
endmodule
